/* cell_net_pkg.sv */
// cell_net_pkg: shared constants and carrier types for the logic module and clock network block.
// assumes a single 125 MHz system clock samples every pin that reaches the block.
package cell_net_pkg;

  // array sizes
  localparam int NUM_REG  = 4;
  localparam int NUM_COMB = 4;
  localparam int LUT_IN   = 5;
  localparam int LUT_SIZE = 32;

  // which data input of a combinational cell carries the optional inverter
  localparam int INV_IDX = 2;

  // the hard clock swallows this many rising edges after power-up
  localparam int          STARTUP_EDGES = 3;
  localparam logic [1:0]  START_CNT_MAX = 2'h3;
  localparam logic [1:0]  START_CNT_RST = 2'h0;

  // register reset value and the levels that clear and preset force
  localparam logic FLOP_RST    = 1'h0;
  localparam logic FLOP_CLEAR  = 1'h0;
  localparam logic FLOP_PRESET = 1'h1;

  // truth table of a two-way mux, out = in2 ? in1 : in0, used by the paired cell flop
  localparam logic [LUT_SIZE-1:0] LATCH_LUT = 32'hCACACACA;

  // synchroniser lane order
  localparam int PIN_HARD  = 0;
  localparam int PIN_A     = 1;
  localparam int PIN_B     = 2;
  localparam int PIN_TRST  = 3;
  localparam int PIN_COUNT = 4;

  // clock source of a register module
  typedef enum logic [1:0] {
    SRC_HARD,
    SRC_ROUTED_A,
    SRC_ROUTED_B
  } clk_src_t;

  // clock tap offered to combinational cells: the hard clock is never a choice
  typedef enum logic [1:0] {
    TAP_NONE,
    TAP_ROUTED_A,
    TAP_ROUTED_B
  } comb_tap_t;

  // static configuration of one register module
  typedef struct packed {
    logic     falling_edge;
    clk_src_t src;
  } reg_cfg_t;

  // live controls of one register module
  typedef struct packed {
    logic d;
    logic clear;
    logic preset;
    logic enable_select_0;
    logic enable_select_1;
  } reg_ctl_t;

  // configuration of one combinational cell
  typedef struct packed {
    logic [LUT_SIZE-1:0] lut;
    logic                invert;
    comb_tap_t           tap;
  } comb_cfg_t;

endpackage

/* comb_cell.sv */
// comb_cell: five-input combinational module with one invertible input.
// assumes the caller registers the result; no state is kept here.
`timescale 1ns/100ps

module comb_cell (
  input  wire logic [cell_net_pkg::LUT_IN-1:0]   data_in,
  input  wire logic [cell_net_pkg::LUT_SIZE-1:0] lut_in,
  input  wire logic                              invert_in,
  output logic                                   result_out
);

  logic [cell_net_pkg::LUT_IN-1:0] index;

  // the invertible input flips before the table lookup, which only reorders the 32 table entries
  always_comb begin
    index                         = data_in;
    index[cell_net_pkg::INV_IDX]  = data_in[cell_net_pkg::INV_IDX] ^ invert_in;
    result_out                    = lut_in[index];
  end

endmodule // comb_cell

/* logic_module_clock_network.sv */
// logic_module_clock_network: register modules, combinational modules and the three clock networks.
// assumes clock pins and the test reset pin are asynchronous; all other inputs come from logic on ref_clk_in.
`timescale 1ns/100ps

module logic_module_clock_network (
  input  wire logic                                                ref_clk_in,
  input  wire logic                                                reset_in,
  input  wire logic                                                hard_clock_pin_in,
  input  wire logic                                                routed_clock_a_pin_in,
  input  wire logic                                                routed_clock_b_pin_in,
  input  wire logic                                                internal_clock_buffer_a_in,
  input  wire logic                                                internal_clock_buffer_b_in,
  input  wire logic                                                routed_a_internal_sel_in,
  input  wire logic                                                routed_b_internal_sel_in,
  input  wire logic                                                test_reset_reserved_in,
  input  wire logic                                                test_reset_pin_in,
  input  wire cell_net_pkg::reg_cfg_t  [cell_net_pkg::NUM_REG-1:0]  reg_cfg_in,
  input  wire cell_net_pkg::reg_ctl_t  [cell_net_pkg::NUM_REG-1:0]  reg_ctl_in,
  input  wire cell_net_pkg::comb_cfg_t [cell_net_pkg::NUM_COMB-1:0] comb_cfg_in,
  input  wire logic [cell_net_pkg::NUM_COMB-1:0][cell_net_pkg::LUT_IN-1:0] comb_data_in,
  input  wire logic                                                paired_d_in,
  output logic [cell_net_pkg::NUM_REG-1:0]                         reg_q_out,
  output logic [cell_net_pkg::NUM_COMB-1:0]                        comb_out,
  output logic                                                     paired_cell_flop_out,
  output logic                                                     hard_clock_live_out
);

  logic [cell_net_pkg::PIN_COUNT-1:0] pin_meta_q;
  logic [cell_net_pkg::PIN_COUNT-1:0] pin_sync_q;
  logic                               net_a;
  logic                               net_b;
  logic                               net_hard_prev_q;
  logic                               net_a_prev_q;
  logic                               net_b_prev_q;
  logic                               hard_rise;
  logic                               hard_fall;
  logic                               a_rise;
  logic                               a_fall;
  logic                               b_rise;
  logic                               b_fall;
  logic [1:0]                         start_cnt_q;
  logic                               bypass;
  logic                               hard_live;
  logic [cell_net_pkg::NUM_REG-1:0]   reg_q;
  logic [cell_net_pkg::NUM_COMB-1:0]  comb_q;
  logic                               master_q;
  logic                               slave_q;
  logic                               master_d;
  logic                               slave_d;

  // two flops on every asynchronous pin; the first stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    pin_meta_q <= {test_reset_pin_in, routed_clock_b_pin_in, routed_clock_a_pin_in, hard_clock_pin_in};
    pin_sync_q <= pin_meta_q;
  end

  // routed networks take the pin or the internal clock buffer
  assign net_a = routed_a_internal_sel_in ? internal_clock_buffer_a_in : pin_sync_q[cell_net_pkg::PIN_A];
  assign net_b = routed_b_internal_sel_in ? internal_clock_buffer_b_in : pin_sync_q[cell_net_pkg::PIN_B];

  // previous levels for edge detection on each network
  // reset loads the live level, so a pin that idles high gives no false edge after reset
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      net_hard_prev_q <= pin_sync_q[cell_net_pkg::PIN_HARD];
      net_a_prev_q    <= net_a;
      net_b_prev_q    <= net_b;
    end else begin
      net_hard_prev_q <= pin_sync_q[cell_net_pkg::PIN_HARD];
      net_a_prev_q    <= net_a;
      net_b_prev_q    <= net_b;
    end
  end

  assign hard_rise = pin_sync_q[cell_net_pkg::PIN_HARD] & ~net_hard_prev_q;
  assign hard_fall = ~pin_sync_q[cell_net_pkg::PIN_HARD] & net_hard_prev_q;
  assign a_rise    = net_a & ~net_a_prev_q;
  assign a_fall    = ~net_a & net_a_prev_q;
  assign b_rise    = net_b & ~net_b_prev_q;
  assign b_fall    = ~net_b & net_b_prev_q;

  // reserved test reset tied low skips the start-up blocking
  assign bypass = test_reset_reserved_in & ~pin_sync_q[cell_net_pkg::PIN_TRST];

  // count swallowed hard edges after power-up; guards against a slow power-on reset
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      start_cnt_q <= cell_net_pkg::START_CNT_RST;
    end else if (hard_rise && start_cnt_q != cell_net_pkg::START_CNT_MAX) begin
      start_cnt_q <= start_cnt_q + 2'h1;
    end
  end

  assign hard_live           = bypass | (start_cnt_q == cell_net_pkg::START_CNT_MAX);
  assign hard_clock_live_out = hard_live;

  // register modules: per-register source and polarity select the effective edge
  for (genvar i = 0; i < cell_net_pkg::NUM_REG; i++) begin : g_reg
    logic edge_hit;
    logic enable;

    always_comb begin
      case (reg_cfg_in[i].src)
        cell_net_pkg::SRC_HARD:     edge_hit = hard_live & (reg_cfg_in[i].falling_edge ? hard_fall : hard_rise);
        cell_net_pkg::SRC_ROUTED_A: edge_hit = reg_cfg_in[i].falling_edge ? a_fall : a_rise;
        cell_net_pkg::SRC_ROUTED_B: edge_hit = reg_cfg_in[i].falling_edge ? b_fall : b_rise;
        default:                    edge_hit = 1'h0;
      endcase
    end

    // register holds while both selects are low
    assign enable = reg_ctl_in[i].enable_select_0 | reg_ctl_in[i].enable_select_1;

    // clear first, then preset, both ahead of the enable
    always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
        reg_q[i] <= cell_net_pkg::FLOP_RST;
      end else if (reg_ctl_in[i].clear) begin
        reg_q[i] <= cell_net_pkg::FLOP_CLEAR;
      end else if (reg_ctl_in[i].preset) begin
        reg_q[i] <= cell_net_pkg::FLOP_PRESET;
      end else if (edge_hit && enable) begin
        reg_q[i] <= reg_ctl_in[i].d;
      end
    end
  end

  assign reg_q_out = reg_q;

  // combinational modules; the tap on input 4 offers routed clocks only, never the hard clock
  for (genvar j = 0; j < cell_net_pkg::NUM_COMB; j++) begin : g_comb
    logic [cell_net_pkg::LUT_IN-1:0] cell_in;
    logic                            cell_res;

    always_comb begin
      cell_in = comb_data_in[j];
      case (comb_cfg_in[j].tap)
        cell_net_pkg::TAP_ROUTED_A: cell_in[cell_net_pkg::LUT_IN-1] = net_a;
        cell_net_pkg::TAP_ROUTED_B: cell_in[cell_net_pkg::LUT_IN-1] = net_b;
        default:                    cell_in[cell_net_pkg::LUT_IN-1] = comb_data_in[j][cell_net_pkg::LUT_IN-1];
      endcase
    end

    comb_cell u_cell (
      .data_in    (cell_in),
      .lut_in     (comb_cfg_in[j].lut),
      .invert_in  (comb_cfg_in[j].invert),
      .result_out (cell_res)
    );

    // registered so the output is glitch free, at one cycle of latency
    always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
        comb_q[j] <= 1'h0;
      end else begin
        comb_q[j] <= cell_res;
      end
    end
  end

  assign comb_out = comb_q;

  // paired cell flop: master mux transparent while routed clock a is low (inverted gate), slave while high
  comb_cell u_master (
    .data_in    ({2'h0, net_a, paired_d_in, master_q}),
    .lut_in     (cell_net_pkg::LATCH_LUT),
    .invert_in  (1'h1),
    .result_out (master_d)
  );

  comb_cell u_slave (
    .data_in    ({2'h0, net_a, master_q, slave_q}),
    .lut_in     (cell_net_pkg::LATCH_LUT),
    .invert_in  (1'h0),
    .result_out (slave_d)
  );

  // the loop is closed through flops; slower than a register module, fine off critical paths
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      master_q <= cell_net_pkg::FLOP_RST;
      slave_q  <= cell_net_pkg::FLOP_RST;
    end else begin
      master_q <= master_d;
      slave_q  <= slave_d;
    end
  end

  assign paired_cell_flop_out = slave_q;

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  chk_clear_wins: assert property (
    reg_ctl_in[1].clear && reg_ctl_in[1].preset |=> reg_q_out[1] == cell_net_pkg::FLOP_CLEAR)
    else $error("clear did not win over preset");

  chk_preset_no_enable: assert property (
    !reg_ctl_in[1].clear && reg_ctl_in[1].preset && !reg_ctl_in[1].enable_select_0
      && !reg_ctl_in[1].enable_select_1 |=> reg_q_out[1] == cell_net_pkg::FLOP_PRESET)
    else $error("preset blocked by enable");

  chk_enable_hold: assert property (
    !reg_ctl_in[0].clear && !reg_ctl_in[0].preset && !reg_ctl_in[0].enable_select_0
      && !reg_ctl_in[0].enable_select_1 |=> $stable(reg_q_out[0]))
    else $error("register moved while disabled");

  chk_polarity_edge: assert property (
    reg_cfg_in[2].src == cell_net_pkg::SRC_ROUTED_B && reg_cfg_in[2].falling_edge && b_rise
      && !reg_ctl_in[2].clear && !reg_ctl_in[2].preset |=> $stable(reg_q_out[2]))
    else $error("falling-edge register loaded on rising edge");

  chk_hard_blocked: assert property (
    !bypass && start_cnt_q != cell_net_pkg::START_CNT_MAX && hard_rise
      && reg_cfg_in[1].src == cell_net_pkg::SRC_HARD
      && !reg_ctl_in[1].clear && !reg_ctl_in[1].preset |=> $stable(reg_q_out[1]))
    else $error("hard clock edge loaded before start-up edges");

  chk_hard_live_after: assert property (
    $rose(hard_clock_live_out) && !bypass |-> $past(hard_rise))
    else $error("hard clock went live without a counted edge");

  chk_bypass_live: assert property (
    bypass && hard_rise && reg_cfg_in[1].src == cell_net_pkg::SRC_HARD && !reg_cfg_in[1].falling_edge
      && !reg_ctl_in[1].clear && !reg_ctl_in[1].preset
      && (reg_ctl_in[1].enable_select_0 || reg_ctl_in[1].enable_select_1)
      |=> reg_q_out[1] == $past(reg_ctl_in[1].d))
    else $error("bypass did not let the first hard edge load");

  chk_comb_table: assert property (
    comb_cfg_in[0].tap == cell_net_pkg::TAP_NONE && !comb_cfg_in[0].invert
      |=> comb_out[0] == $past(comb_cfg_in[0].lut[comb_data_in[0]]))
    else $error("combinational output does not match table");

  chk_paired_update: assert property (
    !$stable(paired_cell_flop_out) |-> $past(net_a))
    else $error("paired flop changed with clock low");

  cov_hard_live: cover property (!hard_clock_live_out ##1 hard_clock_live_out);
  cov_fall_load: cover property (reg_cfg_in[2].falling_edge && b_fall ##1 $changed(reg_q_out[2]));
  cov_paired_load: cover property ($rose(paired_cell_flop_out));

endmodule // logic_module_clock_network

/* tb.sv */
// tb: self-checking bench for the register modules, combinational cells and clock networks.
// assumes the design samples every pin on ref_clk_in rising edges; the bench drives on falling edges.
`timescale 1ns/100ps

module tb;
  logic                                                    ref_clk_in, reset_in, hard_pin, a_pin, b_pin;
  logic                                                    int_a, int_b, a_sel, b_sel, trst_rsv, trst_pin, paired_d;
  cell_net_pkg::reg_cfg_t  [cell_net_pkg::NUM_REG-1:0]     reg_cfg;
  cell_net_pkg::reg_ctl_t  [cell_net_pkg::NUM_REG-1:0]     reg_ctl;
  cell_net_pkg::comb_cfg_t [cell_net_pkg::NUM_COMB-1:0]    comb_cfg;
  logic [cell_net_pkg::NUM_COMB-1:0][cell_net_pkg::LUT_IN-1:0] comb_data;
  logic [cell_net_pkg::NUM_REG-1:0]                        reg_q;
  logic [cell_net_pkg::NUM_COMB-1:0]                       comb_q;
  logic                                                    paired_q, live;
  int                                                      errors, checks_done;

  logic_module_clock_network dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .hard_clock_pin_in(hard_pin),
    .routed_clock_a_pin_in(a_pin), .routed_clock_b_pin_in(b_pin),
    .internal_clock_buffer_a_in(int_a), .internal_clock_buffer_b_in(int_b),
    .routed_a_internal_sel_in(a_sel), .routed_b_internal_sel_in(b_sel),
    .test_reset_reserved_in(trst_rsv), .test_reset_pin_in(trst_pin),
    .reg_cfg_in(reg_cfg), .reg_ctl_in(reg_ctl), .comb_cfg_in(comb_cfg), .comb_data_in(comb_data),
    .paired_d_in(paired_d), .reg_q_out(reg_q), .comb_out(comb_q),
    .paired_cell_flop_out(paired_q), .hard_clock_live_out(live)
  );

  // 125 MHz system clock
  initial begin
    ref_clk_in = 1'h0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // case inequality so that an unknown output never counts as a match
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // reset is held six cycles, long enough to flush the pin synchronisers
  task do_reset();
    @(negedge ref_clk_in) reset_in = 1'h1;
    repeat (6) @(negedge ref_clk_in);
    reset_in = 1'h0;
  endtask

  task idle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask

  // one full pulse on a synchronised pin; six cycles each side covers the three-cycle pin latency
  task pulse(input bit on_hard);
    @(negedge ref_clk_in);
    if (on_hard) hard_pin = 1'h1; else a_pin = 1'h1;
    idle(6);
    if (on_hard) hard_pin = 1'h0; else a_pin = 1'h0;
    idle(6);
  endtask

  task test_reset_vals();
    check(reg_q, 32'h0);
    check(comb_q, 32'h0);
    check(paired_q, 32'h0);
    check(live, 32'h0);
    $display("test reset values done");
  endtask

  // first three hard rises are swallowed, the fourth loads; combinational cells never see it
  task test_hard_startup();
    reg_ctl[1] = '{d: 1'h1, clear: 1'h0, preset: 1'h0, enable_select_0: 1'h1, enable_select_1: 1'h0};
    comb_cfg[2] = '{lut: 32'hFFFF0000, invert: 1'h0, tap: cell_net_pkg::TAP_NONE};
    for (int i = 0; i < cell_net_pkg::STARTUP_EDGES; i++) begin
      pulse(1'b1);
      check(reg_q[1], 32'h0);
      check(live, (i == cell_net_pkg::STARTUP_EDGES - 1) ? 32'h1 : 32'h0);
      check(comb_q[2], 32'h0);
    end
    pulse(1'b1);
    check(reg_q[1], 32'h1);
    check(live, 32'h1);
    check(comb_q[2], 32'h0);
    $display("test hard start-up done");
  endtask

  // routed pin clock: no select means no load, then each select alone enables
  task test_routed_enable();
    reg_cfg[0] = '{falling_edge: 1'h0, src: cell_net_pkg::SRC_ROUTED_A};
    reg_ctl[0] = '{d: 1'h1, clear: 1'h0, preset: 1'h0, enable_select_0: 1'h0, enable_select_1: 1'h0};
    pulse(1'b0);
    check(reg_q[0], 32'h0);
    reg_ctl[0].enable_select_1 = 1'h1;
    pulse(1'b0);
    check(reg_q[0], 32'h1);
    reg_ctl[0] = '{d: 1'h0, clear: 1'h0, preset: 1'h0, enable_select_0: 1'h1, enable_select_1: 1'h0};
    pulse(1'b0);
    check(reg_q[0], 32'h0);
    $display("test routed enable done");
  endtask

  // clear wins over preset; both act with the enable low and no clock edge
  task test_clear_preset();
    reg_ctl[1] = '{d: 1'h1, clear: 1'h1, preset: 1'h1, enable_select_0: 1'h0, enable_select_1: 1'h0};
    idle(2);
    check(reg_q[1], 32'h0);
    reg_ctl[1].clear = 1'h0;
    idle(2);
    check(reg_q[1], 32'h1);
    reg_ctl[1].preset = 1'h0;
    $display("test clear preset done");
  endtask

  // internal buffer clock on network b, register set to the falling edge
  task test_falling();
    b_sel = 1'h1;
    reg_cfg[2] = '{falling_edge: 1'h1, src: cell_net_pkg::SRC_ROUTED_B};
    reg_ctl[2] = '{d: 1'h1, clear: 1'h0, preset: 1'h0, enable_select_0: 1'h1, enable_select_1: 1'h0};
    int_b = 1'h1;
    idle(3);
    check(reg_q[2], 32'h0);
    int_b = 1'h0;
    idle(3);
    check(reg_q[2], 32'h1);
    $display("test falling edge done");
  endtask

  // lut lookup with and without the inverter, and the routed clock tap on the top input
  task test_comb();
    a_sel = 1'h1;
    int_a = 1'h0;
    comb_data[0] = 5'h05;
    for (int inv = 0; inv < 2; inv++) begin
      comb_cfg[0] = '{lut: 32'h00000020, invert: inv[0], tap: cell_net_pkg::TAP_NONE};
      idle(2);
      check(comb_q[0], inv ? 32'h0 : 32'h1);
    end
    comb_cfg[1] = '{lut: 32'hFFFF0000, invert: 1'h0, tap: cell_net_pkg::TAP_ROUTED_A};
    comb_data[1] = 5'h00;
    idle(2);
    check(comb_q[1], 32'h0);
    int_a = 1'h1;
    idle(2);
    check(comb_q[1], 32'h1);
    int_a = 1'h0;
    $display("test comb done");
  endtask

  // paired cells capture on the rise of network a and hold while it stays high
  task test_paired();
    paired_d = 1'h1;
    idle(3);
    check(paired_q, 32'h0);
    int_a = 1'h1;
    idle(4);
    check(paired_q, 32'h1);
    paired_d = 1'h0;
    idle(4);
    check(paired_q, 32'h1);
    int_a = 1'h0;
    $display("test paired done");
  endtask

  // reserved test reset held low: the very first hard rise loads
  task test_bypass();
    trst_rsv = 1'h1;
    trst_pin = 1'h0;
    reg_ctl[1].enable_select_0 = 1'h1;
    do_reset();
    idle(3);
    check(live, 32'h1);
    check(reg_q[1], 32'h0);
    pulse(1'b1);
    check(reg_q[1], 32'h1);
    $display("test bypass done");
  endtask

  // watchdog: the whole sequence needs well under 2,000 cycles
  initial begin
    #100000;
    errors++;
    end_sim();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    reset_in = 1'h1;
    {hard_pin, a_pin, b_pin, int_a, int_b, a_sel, b_sel, trst_rsv, trst_pin, paired_d} = '0;
    reg_cfg = '0;
    reg_ctl = '0;
    comb_cfg = '0;
    comb_data = '0;
    do_reset();
    test_reset_vals();
    test_hard_startup();
    test_routed_enable();
    test_clear_preset();
    test_falling();
    test_comb();
    test_paired();
    test_bypass();
    end_sim();
  end
endmodule // tb
